// ===== core/qec_pkg.sv
package qec_pkg;
    // byte addresses inside the module (low byte status/select, high byte data)
    localparam logic ADDR_STATUS = 1'b0;
    localparam logic ADDR_DATA = 1'b1;
    // status/select field positions
    localparam int SEL_LSB = 0;
    localparam int CLR_EN_BIT = 2;
    localparam int OVF_LSB = 4;
    // reset values
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic CLR_EN_RESET = 1'b0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // per-counter switch settings
    typedef struct packed {
        logic [7:0] level;
        logic irq_enable;
        logic reset_on_overflow;
    } switch_type;
    // module bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic addr;
        logic [7:0] wdata;
    } bus_req_type;
endpackage : qec_pkg

// ===== core/input_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser; a change counts once stages two and three agree
module input_sync (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // async level in, clean level out
    input wire logic i_async,
    output logic o_level
);
    logic s1; // first stage, read only by s2
    logic s2;
    logic s3;
    // shift chain
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // output moves only when the two later stages agree, filtering a one-cycle glitch
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_level <= 1'b0;
        end else if (s2 == s3) begin
            o_level <= s3;
        end
    end
endmodule : input_sync

// ===== core/event_counter.sv
`timescale 1ns/10ps
// one 8-bit up counter with overflow detection
module event_counter (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // control
    input wire logic i_inc,
    input wire logic i_clear,
    input wire qec_pkg::switch_type i_sw,
    // results
    output logic [7:0] o_count,
    output logic o_det
);
    logic [7:0] next_count; // incremented value
    logic watched_old; // watched bit before increment
    logic watched_new; // watched bit after increment
    always_comb begin
        next_count = o_count + 8'h01;
        watched_old = |(o_count & i_sw.level);
        watched_new = |(next_count & i_sw.level);
    end
    // count register; a clear wins over an increment and never flags overflow
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_count <= qec_pkg::COUNT_RESET;
        end else if (i_clear) begin
            o_count <= qec_pkg::COUNT_RESET;
        end else if (i_inc) begin
            if (watched_old && !watched_new && i_sw.reset_on_overflow) begin
                o_count <= qec_pkg::COUNT_RESET;
            end else begin
                o_count <= next_count;
            end
        end
    end
    // detect pulse on the watched bit falling through an increment
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_det <= 1'b0;
        end else begin
            o_det <= i_inc && !i_clear && watched_old && !watched_new;
        end
    end
    det_one_cycle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_det |=> !o_det)
        else $error("detect pulse longer than one cycle");
    clear_no_det_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        i_clear |=> !o_det && o_count == 8'h00)
        else $error("software clear flagged overflow");
endmodule : event_counter

// ===== core/quad_event_counter_prescaler.sv
`timescale 1ns/10ps
module quad_event_counter_prescaler #(
    parameter int NUM_COUNTERS = 4,
    parameter logic [7:0] IDENTITY_CODE = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // field inputs, asynchronous
    input wire logic [NUM_COUNTERS-1:0] i_field,
    // option switches per counter
    input wire qec_pkg::switch_type [NUM_COUNTERS-1:0] i_switch,
    // module bus
    input wire qec_pkg::bus_req_type i_bus,
    input wire logic i_read_clears_interrupt_flag,
    input wire logic i_input_disable_control,
    input wire logic i_input_force_test_control,
    input wire logic i_identity_read_select,
    input wire logic i_counter_reset,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // interrupt request
    output logic o_irq
);
    // the status byte has room for exactly four overflow bits
    if (NUM_COUNTERS != 4) begin : g_bad_count
        $error("status layout serves exactly four counters");
    end

    logic [NUM_COUNTERS-1:0] field_level; // synchronised field levels
    logic [NUM_COUNTERS-1:0] gated_level; // after disable/test gating
    logic [NUM_COUNTERS-1:0] gated_prev; // previous gated level
    logic [NUM_COUNTERS-1:0] edge_seen; // rising edge this cycle
    logic [NUM_COUNTERS-1:0] pending; // increments held during a data read
    logic [NUM_COUNTERS-1:0] inc; // increment issued to counters
    logic [NUM_COUNTERS-1:0] clear; // counter clears
    logic [NUM_COUNTERS-1:0] overflow_detect_pulse; // detect pulses
    logic [NUM_COUNTERS-1:0] overflow_flag; // sticky flags
    logic [7:0] count [NUM_COUNTERS]; // live counts
    logic [1:0] select; // counter select field
    logic clear_enable; // clear-on-read enable
    logic data_read; // read of the data byte
    logic status_read; // read of the status byte
    logic data_hold; // data read in progress
    logic flag_clear; // clearing status read

    always_comb begin
        data_read = i_bus.rd && i_bus.addr == qec_pkg::ADDR_DATA && !i_identity_read_select;
        status_read = i_bus.rd && i_bus.addr == qec_pkg::ADDR_STATUS && !i_identity_read_select;
        data_hold = data_read;
        flag_clear = status_read && i_read_clears_interrupt_flag;
    end

    // per counter input path; each is an independent channel
    genvar g;
    generate
        for (g = 0; g < NUM_COUNTERS; g++) begin : chan
            input_sync u_sync (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_async(i_field[g]),
                .o_level(field_level[g])
            );
            // disable blocks the field, test forces true
            always_comb begin
                gated_level[g] = i_input_force_test_control
                    || (field_level[g] && !i_input_disable_control);
                edge_seen[g] = gated_level[g] && !gated_prev[g];
                inc[g] = !data_hold && (edge_seen[g] || pending[g]);
                clear[g] = i_counter_reset
                    || (data_read && clear_enable && select == 2'(g));
            end
            event_counter u_counter (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_inc(inc[g]),
                .i_clear(clear[g]),
                .i_sw(i_switch[g]),
                .o_count(count[g]),
                .o_det(overflow_detect_pulse[g])
            );
            // remember the edge while a data read holds the counter off
            always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    pending[g] <= 1'b0;
                end else if (data_hold) begin
                    pending[g] <= pending[g] | edge_seen[g];
                end else begin
                    pending[g] <= 1'b0;
                end
            end
            // sticky flag; a new detect wins over the clearing read
            always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    overflow_flag[g] <= 1'b0;
                end else if (overflow_detect_pulse[g]) begin
                    overflow_flag[g] <= 1'b1;
                end else if (flag_clear) begin
                    overflow_flag[g] <= 1'b0;
                end
            end
            flag_sticky_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
                overflow_flag[g] && !flag_clear |=> overflow_flag[g])
                else $error("overflow flag dropped without clearing read");
            det_sets_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
                overflow_detect_pulse[g] |=> overflow_flag[g])
                else $error("detect did not set overflow flag");
            hold_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
                data_read && !clear[g] |=> count[g] == $past(count[g]))
                else $error("counter moved during data read");

            // software reset empties every counter on the next edge
            sw_reset_zero_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                i_counter_reset |=> count[g] == 8'h00)
                else $error("software reset left a count");

            // disable alone must hold the gated level low
            disable_blocks_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                i_input_disable_control && !i_input_force_test_control |-> !gated_level[g])
                else $error("disabled field input reached counter");

            // test control forces the gated level true
            test_forces_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                i_input_force_test_control |-> gated_level[g])
                else $error("test control did not force input");

            // an edge held off by a read is applied once the read ends
            pending_apply_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                pending[g] && !data_hold |-> inc[g])
                else $error("held edge was lost");

            // no increment reaches the counter while the data byte is read
            read_blocks_inc_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                data_hold |-> !inc[g])
                else $error("increment issued during data read");

            // a clear flag stays clear without a detect pulse
            flag_needs_det_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                !overflow_flag[g] && !overflow_detect_pulse[g] |=> !overflow_flag[g])
                else $error("overflow flag set without detect");

            // reading the selected count with clear enabled empties it
            clear_on_read_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                data_read && clear_enable && select == 2'(g) |=> count[g] == 8'h00)
                else $error("count not cleared after read");

            // every increment moves the count, either up or back to zero
            count_moves_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                inc[g] && !clear[g] |=> count[g] != $past(count[g]))
                else $error("increment did not move the count");

            // without increment or clear the count holds
            count_holds_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                !inc[g] && !clear[g] |=> $stable(count[g]))
                else $error("count moved without an event");

            // a detect pulse follows only from an increment
            det_from_inc_a: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                overflow_detect_pulse[g] |-> $past(inc[g]))
                else $error("detect pulse without increment");
        end
    endgenerate

    // edge history of the gated inputs
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gated_prev <= '0;
        end else begin
            gated_prev <= gated_level;
        end
    end

    // select and clear-enable register; writes go only to the status byte
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            select <= qec_pkg::SEL_RESET;
            clear_enable <= qec_pkg::CLR_EN_RESET;
        end else if (i_bus.wr && i_bus.addr == qec_pkg::ADDR_STATUS) begin
            select <= i_bus.wdata[qec_pkg::SEL_LSB +: 2];
            clear_enable <= i_bus.wdata[qec_pkg::CLR_EN_BIT];
        end else if (data_read && clear_enable) begin
            clear_enable <= 1'b0;
        end
    end

    // read data path, registered; count captured before any clear lands
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_bus.rd;
            if (i_bus.rd && i_identity_read_select) begin
                o_rdata <= IDENTITY_CODE;
            end else if (data_read) begin
                o_rdata <= count[select];
            end else if (status_read) begin
                o_rdata <= {overflow_flag, 1'b0, clear_enable, select};
            end
        end
    end

    // interrupt request from enabled flags
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(overflow_flag & {i_switch[3].irq_enable, i_switch[2].irq_enable,
                i_switch[1].irq_enable, i_switch[0].irq_enable});
        end
    end

    irq_follows_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        overflow_flag[0] && i_switch[0].irq_enable && $stable(overflow_flag) |=> o_irq)
        else $error("enabled overflow did not raise interrupt");
    clr_en_drop_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        data_read && clear_enable && !i_bus.wr |=> !clear_enable)
        else $error("clear enable not dropped after data read");
    rclear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        flag_clear && overflow_detect_pulse == '0 |=> overflow_flag == '0)
        else $error("clearing status read left flags set");
    id_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        i_bus.rd && i_identity_read_select |=> o_rdata == IDENTITY_CODE)
        else $error("identity byte wrong");

    // every read is answered one cycle later
    rvalid_answer_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        i_bus.rd |=> o_rvalid)
        else $error("read not answered");

    // no answer appears without a read
    rvalid_quiet_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        !i_bus.rd |=> !o_rvalid)
        else $error("answer without read");

    // a status write loads the select field
    select_load_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        i_bus.wr && i_bus.addr == qec_pkg::ADDR_STATUS
        |=> select == $past(i_bus.wdata[1:0]))
        else $error("select not loaded");

    // a status write loads the clear-enable bit
    clr_en_load_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        i_bus.wr && i_bus.addr == qec_pkg::ADDR_STATUS
        |=> clear_enable == $past(i_bus.wdata[2]))
        else $error("clear enable not loaded");

    // writes to the read-only data byte change nothing
    data_wr_ignored_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        i_bus.wr && i_bus.addr == qec_pkg::ADDR_DATA && !data_read
        |=> $stable(select) && $stable(clear_enable))
        else $error("data byte write took effect");

    // select holds between status writes
    select_hold_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        !(i_bus.wr && i_bus.addr == qec_pkg::ADDR_STATUS) |=> $stable(select))
        else $error("select moved without write");

    // clear enable stays until a data read or a new write
    clr_en_hold_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        clear_enable && !data_read && !i_bus.wr |=> clear_enable)
        else $error("clear enable lost early");

    // the status byte mirrors flags, enable and select
    status_byte_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        status_read |=> o_rdata == {$past(overflow_flag), 1'b0, $past(clear_enable),
            $past(select)})
        else $error("status byte wrong");

    // the data byte carries the selected count taken before any clear
    data_byte_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        data_read |=> o_rdata == $past(count[select]))
        else $error("data byte wrong");

    // read data holds between reads
    rdata_hold_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        !i_bus.rd |=> $stable(o_rdata))
        else $error("read data moved without read");

    // no flag, no interrupt
    irq_needs_flag_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        overflow_flag == '0 |=> !o_irq)
        else $error("interrupt without overflow flag");
endmodule : quad_event_counter_prescaler

// ===== bench/io_ctrl_model.sv
`timescale 1ns/10ps
// host side of the module bus: one-cycle read and write pulses
module io_ctrl_model (
    // clock
    input wire logic i_ref_clk,
    // answer from the device
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    // request to the device
    output qec_pkg::bus_req_type o_bus
);
    // bus idles with no request
    initial begin
        o_bus = '0;
    end
    // write the status/select byte; the host picks a counter before a data read
    task automatic write_status(input logic [7:0] data);
        @(posedge i_ref_clk);
        #1;
        o_bus = '{rd: 1'b0, wr: 1'b1, addr: qec_pkg::ADDR_STATUS, wdata: data};
        @(posedge i_ref_clk);
        #1;
        // released data lines show junk, so a stale byte cannot be relied on
        o_bus = '{rd: 1'b0, wr: 1'b0, addr: 1'b0, wdata: ~data};
    endtask : write_status
    // one-cycle read pulse, then a bounded wait for the answer
    task automatic read_byte(input logic addr, output logic [7:0] data, output logic ok);
        ok = 1'b0;
        data = 8'h00;
        @(posedge i_ref_clk);
        #1;
        o_bus = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'hA5};
        @(posedge i_ref_clk);
        #1;
        o_bus = '0;
        // the valid pulse stands one cycle, so it is looked at every cycle
        for (int i = 0; i < 4 && !ok; i++) begin
            if (i_rvalid === 1'b1) begin
                ok = 1'b1;
                data = i_rdata;
            end else begin
                @(posedge i_ref_clk);
                #1;
            end
        end
    endtask : read_byte
endmodule : io_ctrl_model

// ===== bench/tb.sv
`timescale 1ns/10ps
module tb;
    // arbitrary identity value, only has to differ from any count seen
    localparam logic [7:0] ID = 8'h3C;
    // design stimulus and results
    logic clk;
    logic rst_b;
    logic [3:0] field;
    qec_pkg::switch_type [3:0] sw;
    qec_pkg::bus_req_type bus;
    logic read_clears_interrupt_flag, dis, tst, ids, crst;
    logic [7:0] rdata;
    logic rvalid, irq;
    // bookkeeping
    int n_mismatch = 0;
    int n_tests = 0;
    logic [7:0] d;
    logic ok;
    logic [7:0] exp_cnt [4] = '{8'h00, 8'h08, 8'h08, 8'h00};

    quad_event_counter_prescaler #(.NUM_COUNTERS(4), .IDENTITY_CODE(ID)) dut_u (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_field(field), .i_switch(sw), .i_bus(bus),
        .i_read_clears_interrupt_flag(read_clears_interrupt_flag), .i_input_disable_control(dis),
        .i_input_force_test_control(tst), .i_identity_read_select(ids),
        .i_counter_reset(crst), .o_rdata(rdata), .o_rvalid(rvalid), .o_irq(irq));

    io_ctrl_model host_u (.i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_bus(bus));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // verdict and end of run
    task automatic close_out();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // read one byte and compare; a missing answer ends the run
    task automatic rd(input logic addr, input logic [7:0] exp);
        host_u.read_byte(addr, d, ok);
        if (!ok) begin
            n_mismatch++;
            close_out();
        end else begin
            check(d, exp);
        end
    endtask : rd
    // count pulses on the test control, or on field input 0
    task automatic pulses(input int n, input logic use_field);
        repeat (n) begin
            @(posedge clk);
            #1;
            if (use_field) field[0] = 1'b1;
            else tst = 1'b1;
            repeat (4) @(posedge clk);
            #1;
            field[0] = 1'b0;
            tst = 1'b0;
            repeat (4) @(posedge clk);
        end
        // let the synchroniser, flags and request settle
        repeat (6) @(posedge clk);
        #1;
    endtask : pulses

    // main sequence
    initial begin
        rst_b = 1'b0;
        field = 4'h0;
        {read_clears_interrupt_flag, dis, tst, ids, crst} = 5'h00;
        // exactly one level switch per counter, each counter set differently
        sw[0] = '{level: 8'h04, irq_enable: 1'b1, reset_on_overflow: 1'b1};
        sw[1] = '{level: 8'h04, irq_enable: 1'b0, reset_on_overflow: 1'b0};
        sw[2] = '{level: 8'h08, irq_enable: 1'b0, reset_on_overflow: 1'b0};
        sw[3] = '{level: 8'h01, irq_enable: 1'b0, reset_on_overflow: 1'b1};
        repeat (16) @(posedge clk);
        #1;
        rst_b = 1'b1;
        rd(qec_pkg::ADDR_STATUS, 8'h00);
        ids = 1'b1;
        rd(qec_pkg::ADDR_DATA, ID);
        rd(qec_pkg::ADDR_STATUS, ID);
        ids = 1'b0;
        $display("test reset and identity done");
        // field edge is blocked while the test control counts all four
        dis = 1'b1;
        field[2] = 1'b1;
        pulses(8, 1'b0);
        field[2] = 1'b0;
        // the synchronised level must fall before the gate opens, or it counts once
        repeat (6) @(posedge clk);
        #1;
        dis = 1'b0;
        check({7'h00, irq}, 8'h01);
        rd(qec_pkg::ADDR_STATUS, 8'hB0);
        for (int k = 0; k < 4; k++) begin
            host_u.write_status(8'(k));
            rd(qec_pkg::ADDR_DATA, exp_cnt[k]);
        end
        $display("test overflow and select done");
        // flags survive a plain read, a flagged read clears them
        rd(qec_pkg::ADDR_STATUS, 8'hB3);
        read_clears_interrupt_flag = 1'b1;
        rd(qec_pkg::ADDR_STATUS, 8'hB3);
        read_clears_interrupt_flag = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check({7'h00, irq}, 8'h00);
        rd(qec_pkg::ADDR_STATUS, 8'h03);
        // clear on read of counter 1
        host_u.write_status(8'h05);
        rd(qec_pkg::ADDR_STATUS, 8'h05);
        rd(qec_pkg::ADDR_DATA, 8'h08);
        rd(qec_pkg::ADDR_STATUS, 8'h01);
        rd(qec_pkg::ADDR_DATA, 8'h00);
        $display("test flag clear and clear enable done");
        // counter 2 at 8 watches bit 3: a software reset must not flag it
        host_u.write_status(8'h02);
        @(posedge clk);
        #1;
        crst = 1'b1;
        @(posedge clk);
        #1;
        crst = 1'b0;
        repeat (3) @(posedge clk);
        rd(qec_pkg::ADDR_DATA, 8'h00);
        rd(qec_pkg::ADDR_STATUS, 8'h02);
        // long run: counter 1 climbs to 250 without wrapping, counter 0 is radix 8
        pulses(250, 1'b0);
        host_u.write_status(8'h01);
        rd(qec_pkg::ADDR_DATA, 8'hFA);
        host_u.write_status(8'h00);
        rd(qec_pkg::ADDR_DATA, 8'h02);
        pulses(1, 1'b1);
        rd(qec_pkg::ADDR_DATA, 8'h03);
        $display("test reset, wrap and field count done");
        close_out();
    end
endmodule : tb
